// [logic/isdp_regs_defs.vh]
/*
 * register offsets, field positions, reset values and timing counts
 * for the irq shaping, dma start and power-down register group.
 * assumes a 40 MHz system clock.
 */
`ifndef ISDP_REGS_DEFS_VH
`define ISDP_REGS_DEFS_VH

`define ISDP_ADDR_W 16
`define ISDP_OFF_SHAPE 16'h0340
`define ISDP_OFF_DMA 16'h0344
`define ISDP_OFF_PWR 16'h0354

`define ISDP_SPACE_MSB 31
`define ISDP_SPACE_LSB 24
`define ISDP_PULSE_MSB 15
`define ISDP_PULSE_LSB 0
`define ISDP_SHAPE_RESET 32'h0000000F

`define ISDP_DMA_MSB 15
`define ISDP_DMA_LSB 0

`define ISDP_PWR_RESET 32'h03E81BA0
`define ISDP_WAKE_MSB 31
`define ISDP_WAKE_LSB 16
`define ISDP_P3PD_BIT 12
`define ISDP_P2PD_BIT 11
`define ISDP_BATDET_BIT 10
`define ISDP_BIAS_BIT 5
`define ISDP_VREG_BIT 4
`define ISDP_OC3_BIT 3
`define ISDP_OC2_BIT 2
`define ISDP_OC1_BIT 1
`define ISDP_CLKG_BIT 0

`define ISDP_CLK_HZ 40000000
`define ISDP_UFRAME_US 125
// cycle counts given directly: the product overflows 32-bit math
`define ISDP_UFRAME_CYC 16'h1388
`define ISDP_TICK_US 10
`define ISDP_TICK_CYC 16'h0190

`endif

// [logic/isdp_ticker.v]
/*
 * free-running tick generator: one-cycle pulse every PERIOD clocks.
 * assumes PERIOD of at least 2 and below 65536.
 */
`timescale 1ns/100ps
`default_nettype none
module isdp_ticker #(
  parameter [15:0] PERIOD = 16'h0010
) (
  input wire clk_sys, // system clock
  input wire resetn, // async reset, active low
  output reg tick_q // one-cycle tick
);
  reg [15:0] cnt_q;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q == PERIOD - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [logic/isdp_regs.v]
/*
 * irq shaping, dma start address and power-down control registers,
 * with the edge interrupt pulse shaper and the wake-up window timer.
 * assumes a synchronous register port on clk_sys; event and wake
 * inputs come from logic on the same clock.
 * limitations: the gap counts free-running microframe ticks, so the
 * real gap may be up to one microframe short; reserved bits are
 * stored as written; a zero pulse length still gives one cycle.
 * leaving level mode drops the line unless an event fires in that cycle.
 */
// Summary of operation
// - byte 31:24 sets least edge irq gap
// - zero gap fires edge irq at once
// - gap applies in edge mode only
// - edge irq held pulse-cycles clocks long
// - pulse field resets to fifteen, rest zero
// - write-only dma start address, low 16
// - read-write power-down control register
// - upper half sets wake window, 10us ticks
// - pull-down bits connect port pull-downs
`timescale 1ns/100ps
`default_nettype none
`include "isdp_regs_defs.vh"
module isdp_regs (
  input wire clk_sys, // system clock, 40 MHz
  input wire resetn, // async reset, active low
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  input wire [15:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // write data
  output reg [31:0] reg_rdata_q, // read data, valid cycle after rd
  input wire irq_event, // qualifying interrupt event pulse
  input wire irq_level_mode, // 1 = level mode, 0 = edge mode
  input wire wake_event, // wake-up event pulse
  input wire suspend_req, // device is in suspend
  output reg irq_q, // interrupt output, active high
  output reg [15:0] dma_start_addr_q, // dma start address
  output reg dma_addr_load_q, // pulse: new dma address written
  output reg awake_q, // wake window open
  output reg third_port_pulldown_q, // port 3 pull-downs connected
  output reg second_port_pulldown_q, // port 2 pull-downs connected
  output reg battery_detector_power_q, // 1 = detector off in suspend
  output reg bias_circuit_on_q, // bias circuit enable
  output reg regulator_on_q, // regulator control
  output reg third_overcurrent_power_q, // overcurrent 3 power
  output reg second_overcurrent_power_q, // overcurrent 2 power
  output reg first_overcurrent_power_q, // overcurrent 1 power
  output reg core_clock_gate_q // core clock enable
);
  reg [31:0] shape_q;
  reg [31:0] pwr_q;
  reg [15:0] pulse_cnt_q;
  reg [7:0] gap_cnt_q;
  reg pending_q;
  reg [15:0] wake_cnt_q;
  wire uframe_tick;
  wire wake_tick;
  wire wr_shape;
  wire wr_dma;
  wire wr_pwr;
  wire [7:0] min_gap;
  wire [15:0] pulse_len;
  wire gap_busy;
  wire fire;
  wire [15:0] pulse_load;
  wire [15:0] wake_len;
  wire wake_start;

  isdp_ticker #(
    .PERIOD(`ISDP_UFRAME_CYC)
  ) u_uframe (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick_q(uframe_tick)
  );

  isdp_ticker #(
    .PERIOD(`ISDP_TICK_CYC)
  ) u_wake_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick_q(wake_tick)
  );

  assign wr_shape = reg_wr && (reg_addr == `ISDP_OFF_SHAPE);
  assign wr_dma = reg_wr && (reg_addr == `ISDP_OFF_DMA);
  assign wr_pwr = reg_wr && (reg_addr == `ISDP_OFF_PWR);
  assign min_gap = shape_q[`ISDP_SPACE_MSB:`ISDP_SPACE_LSB];
  assign pulse_len = shape_q[`ISDP_PULSE_MSB:`ISDP_PULSE_LSB];
  // zero length still gives one cycle so no event is lost
  assign pulse_load = (pulse_len == 16'h0000) ? 16'h0001 : pulse_len;
  assign wake_len = pwr_q[`ISDP_WAKE_MSB:`ISDP_WAKE_LSB];
  // a zero window never opens, so the device stays asleep
  assign wake_start = wake_event && (wake_len != 16'h0000);

  // register storage; reserved bits stored as written since software
  // is expected to keep them at reset value
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shape_q <= `ISDP_SHAPE_RESET;
      pwr_q <= `ISDP_PWR_RESET;
      dma_start_addr_q <= 16'h0000;
      dma_addr_load_q <= 1'b0;
    end else begin
      // strobe lets the transfer engine reload its pointer
      dma_addr_load_q <= wr_dma;
      if (wr_shape) begin
        shape_q <= reg_wdata;
      end
      if (wr_pwr) begin
        pwr_q <= reg_wdata;
      end
      if (wr_dma) begin
        dma_start_addr_q <= reg_wdata[`ISDP_DMA_MSB:`ISDP_DMA_LSB];
      end
    end
  end

  // read path; dma start is write-only and reads as zero
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ISDP_OFF_SHAPE: reg_rdata_q <= shape_q;
        `ISDP_OFF_PWR: reg_rdata_q <= pwr_q;
        `ISDP_OFF_DMA: reg_rdata_q <= 32'h00000000;
        default: reg_rdata_q <= 32'h00000000;
      endcase
    end
  end

  // decoded power controls straight from flops; they lag the
  // register by one cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      third_port_pulldown_q <= 1'b0;
      second_port_pulldown_q <= 1'b0;
      battery_detector_power_q <= 1'b0;
      bias_circuit_on_q <= 1'b0;
      regulator_on_q <= 1'b0;
      third_overcurrent_power_q <= 1'b0;
      second_overcurrent_power_q <= 1'b0;
      first_overcurrent_power_q <= 1'b0;
      core_clock_gate_q <= 1'b0;
    end else begin
      third_port_pulldown_q <= pwr_q[`ISDP_P3PD_BIT];
      second_port_pulldown_q <= pwr_q[`ISDP_P2PD_BIT];
      battery_detector_power_q <= pwr_q[`ISDP_BATDET_BIT];
      bias_circuit_on_q <= pwr_q[`ISDP_BIAS_BIT];
      regulator_on_q <= pwr_q[`ISDP_VREG_BIT];
      third_overcurrent_power_q <= pwr_q[`ISDP_OC3_BIT];
      second_overcurrent_power_q <= pwr_q[`ISDP_OC2_BIT];
      first_overcurrent_power_q <= pwr_q[`ISDP_OC1_BIT];
      core_clock_gate_q <= pwr_q[`ISDP_CLKG_BIT];
    end
  end

  // gap counts whole microframe ticks after each pulse start, so the
  // real gap may be up to one microframe short of a whole count
  // a spacing field cleared to zero releases held events at once
  assign gap_busy = (gap_cnt_q != 8'h00) && (min_gap != 8'h00) &&
    !irq_level_mode;
  assign fire = !irq_level_mode && (pulse_cnt_q == 16'h0000) &&
    !gap_busy && (irq_event || pending_q);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      pulse_cnt_q <= 16'h0000;
      gap_cnt_q <= 8'h00;
      pending_q <= 1'b0;
    end else if (irq_level_mode) begin
      // level mode: line follows held events, no spacing
      irq_q <= irq_event || pending_q;
      pending_q <= 1'b0;
      pulse_cnt_q <= 16'h0000;
      gap_cnt_q <= 8'h00;
    end else begin
      if (fire) begin
        pending_q <= 1'b0;
        pulse_cnt_q <= pulse_load;
        irq_q <= 1'b1;
        gap_cnt_q <= min_gap;
      end else begin
        if (irq_event) begin
          pending_q <= 1'b1;
        end
        // idle count also drops a line left high by level mode
        if (pulse_cnt_q <= 16'h0001) begin
          irq_q <= 1'b0;
        end
        if (pulse_cnt_q != 16'h0000) begin
          pulse_cnt_q <= pulse_cnt_q - 16'h0001;
        end
        if (uframe_tick && gap_cnt_q != 8'h00) begin
          gap_cnt_q <= gap_cnt_q - 8'h01;
        end
      end
    end
  end

  // wake window: counts 10us ticks after a wake event; zero never wakes
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wake_cnt_q <= 16'h0000;
      awake_q <= 1'b0;
    // leaving suspend closes the window at once
    end else if (!suspend_req) begin
      wake_cnt_q <= 16'h0000;
      awake_q <= 1'b0;
    end else if (wake_start) begin
      wake_cnt_q <= wake_len;
      awake_q <= 1'b1;
    end else if (wake_tick && wake_cnt_q != 16'h0000) begin
      wake_cnt_q <= wake_cnt_q - 16'h0001;
      awake_q <= (wake_cnt_q != 16'h0001);
    end
  end
endmodule
`default_nettype wire

// [verification/isdp_host.sv]
/* host model: one strobe per access; reserved bits go out as the caller passes them */
`timescale 1ns/100ps
`default_nettype none
module isdp_host (
  input wire logic clk_sys, // clock
  output var logic reg_wr, // write strobe
  output var logic reg_rd, // read strobe
  output var logic [15:0] reg_addr, // address
  output var logic [31:0] reg_wdata, // write data
  input wire logic [31:0] reg_rdata_q // read data
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 50'h0;
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge clk_sys);
    #1;
    // released lines flip so a stale value never matches by luck
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// [verification/isdp_chk_asserts.sv]
/* checks on isdp_regs ports; bound below, shadows register writes */
`timescale 1ns/100ps
`default_nettype none
module isdp_chk (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [15:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // wdata
  input wire logic [31:0] reg_rdata_q, // rdata
  input wire logic irq_event, // event
  input wire logic irq_level_mode, // mode
  input wire logic irq_q // irq
);
  logic [31:0] sh_q, pw_q, gp_q;
  logic [15:0] hi_q;
  wire logic sh_wr = reg_wr && reg_addr == 16'h0340;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sh_q <= 32'h0000000F;
      pw_q <= 32'h03E81BA0;
      hi_q <= 16'h0;
      gp_q <= 32'h7FFFFFFF;
    end else begin
      if (sh_wr) sh_q <= reg_wdata;
      if (reg_wr && reg_addr == 16'h0354) pw_q <= reg_wdata;
      hi_q <= irq_q ? hi_q + 16'h1 : 16'h0;
      // a new spacing value drops the reference point, so the next rise is not checked
      if (sh_wr) gp_q <= 32'h7FFFFFFF;
      else if (irq_q && hi_q == 16'h0) gp_q <= 32'h0;
      else gp_q <= gp_q + 32'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence rise_s;
    irq_q && hi_q == 16'h0 && !irq_level_mode;
  endsequence
  shape_read_a: assert property (
    reg_rd && reg_addr == 16'h0340 |=> reg_rdata_q == $past(sh_q))
    else $error("shaping read wrong");
  power_read_a: assert property (
    reg_rd && reg_addr == 16'h0354 |=> reg_rdata_q == $past(pw_q))
    else $error("power read wrong");
  dma_hidden_a: assert property (
    reg_rd && reg_addr == 16'h0344 |=> reg_rdata_q == 32'h0)
    else $error("dma address readable");
  pulse_len_a: assert property (
    !irq_level_mode && $fell(irq_q) |->
    hi_q == (sh_q[15:0] == 16'h0 ? 16'h1 : sh_q[15:0]))
    else $error("pulse length wrong");
  pulse_hold_a: assert property (
    sh_q[15:0] > 16'h3 ##0 rise_s |-> irq_q [*4])
    else $error("pulse cut short");
  gap_keep_a: assert property (
    sh_q[31:25] != 7'h0 ##0 rise_s |->
    gp_q + 32'h1 >= sh_q[31:24] * 32'h1388 - 32'h1388)
    else $error("spacing too short");
  gap_zero_a: assert property (
    sh_q[31:24] == 8'h0 && !irq_level_mode && irq_event && !irq_q &&
    !$past(irq_q) |=> irq_q) else $error("edge irq late");
  level_follow_a: assert property (
    irq_level_mode && irq_event ##1 irq_level_mode |-> irq_q)
    else $error("level irq missing");
endmodule
bind isdp_regs isdp_chk u_chk (.clk_sys, .resetn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata_q, .irq_event, .irq_level_mode, .irq_q);
`default_nettype wire

// [verification/isdp_regs_tb.sv]
/* bench for isdp_regs; host model drives registers, checker is bound */
`timescale 1ns/100ps
`default_nettype none
module isdp_regs_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic irq_event = 1'b0;
  logic irq_level_mode = 1'b0;
  logic wake_event = 1'b0;
  logic suspend_req = 1'b0;
  logic reg_wr, reg_rd, irq_q, awake_q;
  logic [15:0] reg_addr, dma;
  logic [31:0] reg_wdata, reg_rdata_q, q, p;
  wire logic [8:0] pw;
  logic ld;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, t;
  initial forever #12.5 clk_sys = ~clk_sys;
  isdp_host u_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q);
  isdp_regs u_dut (.clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata_q, .irq_event, .irq_level_mode, .wake_event,
    .suspend_req, .irq_q, .dma_start_addr_q(dma), .dma_addr_load_q(ld),
    .awake_q, .third_port_pulldown_q(pw[8]), .second_port_pulldown_q(pw[7]),
    .battery_detector_power_q(pw[6]), .bias_circuit_on_q(pw[5]),
    .regulator_on_q(pw[4]), .third_overcurrent_power_q(pw[3]),
    .second_overcurrent_power_q(pw[2]), .first_overcurrent_power_q(pw[1]),
    .core_clock_gate_q(pw[0]));
  function automatic logic [8:0] pexp(input logic [31:0] v);
    return {v[12:10], v[5:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    tick();
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic wt(input logic w, input logic v, input int lim);
    n = 0;
    while ((w ? awake_q : irq_q) !== v && n < lim) begin
      tick();
      n++;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hA23B));
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    u_host.acc(1'b0, 16'h0340, 32'h0, q);
    chk(q, 32'h0000000F);
    u_host.acc(1'b0, 16'h0354, 32'h0, q);
    chk(q, 32'h03E81BA0);
    chk(pw, pexp(32'h03E81BA0));
    repeat (3) begin
      p = $urandom;
      u_host.acc(1'b1, 16'h0344, {16'h0, p[15:0]}, q);
      chk(dma, p[15:0]);
      chk(ld, 1'b1);
      u_host.acc(1'b0, 16'h0344, 32'h0, q);
      chk(q, 32'h0);
      chk(ld, 1'b0);
      p = p & 32'hFFFF1C3F | 32'h00000380;
      u_host.acc(1'b1, 16'h0354, p, q);
      u_host.acc(1'b0, 16'h0354, 32'h0, q);
      chk(q, p);
      chk(pw, pexp(p));
    end
    u_host.acc(1'b1, 16'h0354, 32'h00021BA0, q);
    suspend_req = 1'b1;
    pulse(wake_event);
    wt(1'b1, 1'b0, 2000);
    // first 10 us tick may be partial, so allow one tick of slack
    chk(n > 398 && n < 802, 1'b1);
    u_host.acc(1'b1, 16'h0354, 32'h00001BA0, q);
    pulse(wake_event);
    chk(awake_q, 1'b0);
    suspend_req = 1'b0;
    for (int i = 0; i < 5; i++) begin
      p = i < 2 ? i * 15 : $urandom_range(40, 1);
      u_host.acc(1'b1, 16'h0340, p, q);
      pulse(irq_event);
      chk(irq_q, 1'b1);
      wt(1'b0, 1'b0, 100);
      chk(n, p == 0 ? 1 : p);
    end
    u_host.acc(1'b1, 16'h0340, 32'h02000003, q);
    pulse(irq_event);
    wt(1'b0, 1'b0, 100);
    t = n + 4;
    pulse(irq_event);
    pulse(irq_event);
    wt(1'b0, 1'b1, 11000);
    chk(t + n >= 5000 && t + n <= 10010, 1'b1);
    wt(1'b0, 1'b0, 100);
    wt(1'b0, 1'b1, 11000);
    chk(n, 11000);
    irq_level_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      irq_event = !i[0];
      repeat (2) tick();
      chk(irq_q, irq_event);
    end
    test_done();
  end
endmodule
`default_nettype wire
